// File: verilog/ctpw_pkg.sv
package ctpw_pkg;
  // register byte offsets
  localparam logic [7:0] A_START     = 8'h00;
  localparam logic [7:0] A_FUNC      = 8'h04;
  localparam logic [7:0] A_MODE      = 8'h08;
  localparam logic [7:0] A_CAPEN     = 8'h0c;
  localparam logic [7:0] A_CH_BASE   = 8'h20;
  localparam logic [7:0] A_CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STAT    = 8'h04;
  localparam logic [7:0] OFS_CNT     = 8'h08;
  localparam logic [7:0] OFS_GR      = 8'h0c;
  // field positions
  localparam int START_LO = 0;
  localparam int CSEL_LO  = 2;
  localparam int FC_OLSP  = 2;
  localparam int FC_OLSN  = 3;
  localparam int CR_CCLR  = 3;
  localparam int SR_OVF   = 4;
  localparam int SR_UDF   = 5;
  // reset values
  localparam logic [1:0]  RST_START = 2'h0;
  localparam logic [1:0]  RST_CSEL  = 2'h3;
  localparam logic [15:0] RST_GR    = 16'hffff;
  localparam logic [15:0] RST_CNT   = 16'h0000;
  // counter clear select codes
  localparam logic [2:0] CCLR_A    = 3'h1;
  localparam logic [2:0] CCLR_B    = 3'h2;
  localparam logic [2:0] CCLR_SYNC = 3'h3;
  localparam logic [2:0] CCLR_C    = 3'h5;
  localparam logic [2:0] CCLR_D    = 3'h6;
  // combination mode codes
  localparam logic [1:0] CMD_TIMER = 2'h0;
  localparam logic [1:0] CMD_RSYNC = 2'h1;
  localparam logic [1:0] CMD_CP_UF = 2'h2;
  localparam logic [1:0] CMD_CP_PK = 2'h3;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {CLS_NORM, CLS_GE, CLS_ZERO} ctpw_cls_t;
endpackage : ctpw_pkg

// File: verilog/ctpw_timer.sv
// Notes on behaviour
// RULE_01: a counter write colliding with a hardware clear is dropped; counter goes to zero.
// RULE_02: clear select 001 A, 010 B, 011 synchronous, 101 C, 110 D match.
// RULE_03: a read right after a write may see the old value; software inserts a branch.
// RULE_04: software stops the channel before changing the count source select.
// RULE_05: software waits two system clocks after reselecting before stopping the fast oscillator.
// RULE_06: capture input pulses must last at least three operating clocks.
// RULE_07: capture copies the counter into its general register two to three clocks later.
// RULE_08: reset-synchronous entry: stop channel 0, mode 00, then 01, then reprogram.
// RULE_09: software sets positive and negative phase level selects equal for motor control.
// RULE_10: complementary entry: stop both, mode 00, then 10 or 11, then reprogram.
// RULE_11: leaving complementary: stop both counters, then mode 00.
// RULE_12: period and duty general registers are not written while complementary runs.
// RULE_13: buffers are loaded with buffer use off, then buffer use switched back on.
// RULE_14: channel 0 peaks m-1,m,m+1,m; compare A flag and mode 11 transfer at m to m+1.
// RULE_15: on the m+1,m,m-1 steps no compare A flag and no transfer.
// RULE_16: channel 1 troughs 1,0,FFFF,0; underflow flag and mode 10 transfer at 0 to FFFF.
// RULE_17: on the FFFF,0,1 steps no transfer and no overflow flag.
// RULE_18: buffer at or above period transfers at underflow; first normal value follows it.
// RULE_19: buffer zero transfers at period match; first normal value follows it.
// RULE_20: status flags stay set until software writes zero to them.
// RULE_21: with stop select 0, writing 0 to the start bit changes nothing.
// RULE_22: in complementary mode both counters run as one up/down pair.
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module ctpw_timer (
  input  logic        clk,            // 250 MHz operating clock
  input  logic        rstn,           // async reset, active low
  input  logic [7:0]  s_axi_awaddr,   // write address
  input  logic        s_axi_awvalid,  // write address valid
  output logic        s_axi_awready,  // write address ready
  input  logic [31:0] s_axi_wdata,    // write data
  input  logic [3:0]  s_axi_wstrb,    // write byte strobes
  input  logic        s_axi_wvalid,   // write data valid
  output logic        s_axi_wready,   // write data ready
  output logic [1:0]  s_axi_bresp,    // write response
  output logic        s_axi_bvalid,   // write response valid
  input  logic        s_axi_bready,   // write response ready
  input  logic [7:0]  s_axi_araddr,   // read address
  input  logic        s_axi_arvalid,  // read address valid
  output logic        s_axi_arready,  // read address ready
  output logic [31:0] s_axi_rdata,    // read data
  output logic [1:0]  s_axi_rresp,    // read response
  output logic        s_axi_rvalid,   // read data valid
  input  logic        s_axi_rready,   // read data ready
  input  logic [7:0]  timer_io_pin,   // capture inputs, index channel*4+register
  output logic [2:0]  pwm_pos_pin,    // positive phase outputs
  output logic [2:0]  pwm_neg_pin     // negative phase outputs
);

  function automatic logic ch_hit(input logic [7:0] a, input int ch, input logic [7:0] ofs);
    return a == 8'(ctpw_pkg::A_CH_BASE + ch * ctpw_pkg::A_CH_STRIDE + ofs);
  endfunction : ch_hit

  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == ctpw_pkg::A_START) || (a == ctpw_pkg::A_FUNC) ||
          (a == ctpw_pkg::A_MODE) || (a == ctpw_pkg::A_CAPEN);
    for (int c = 0; c < 2; c++) begin
      for (int o = 0; o < 7; o++) begin
        if (ch_hit(a, c, 8'(4 * o))) begin
          hit = 1'b1;
        end
      end
    end
    return hit;
  endfunction : is_mapped

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction : wmerge

  function automatic ctpw_pkg::ctpw_cls_t classify(input logic [15:0] v, input logic [15:0] m);
    if (v == 16'h0000) begin
      return ctpw_pkg::CLS_ZERO;
    end
    if (v >= m) begin
      return ctpw_pkg::CLS_GE;
    end
    return ctpw_pkg::CLS_NORM;
  endfunction : classify

  // free prescaler; a count source is a one-cycle enable taken from it
  function automatic logic src_tick(input logic [2:0] sel, input logic [4:0] p);
    case (sel)
      3'h1:    return p[0];
      3'h2:    return &p[1:0];
      3'h3:    return &p[2:0];
      3'h4:    return &p[4:0];
      default: return 1'b1;
    endcase
  endfunction : src_tick

  // bus-side state
  logic        aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_val;
  logic [3:0]  w_strb_r;
  logic [1:0]  bresp_r, rresp_r;
  logic        wr_fire;
  // timer state
  logic [1:0]  start_r, csel_r, cmd_r;
  logic        olsp_r, olsn_r, dir_up_r;
  logic [3:0]  bufen_r;
  logic [7:0]  capen_r, cap_d1_r, cap_d2_r, cap_ev;
  logic [4:0]  psc_r;
  logic [5:0]  ctrl_r [2];
  logic [5:0]  stat_r [2];
  logic [15:0] cnt_r [2];
  logic [15:0] gr_r [2][4];
  logic [2:0]  pos_r, neg_r;
  ctpw_pkg::ctpw_cls_t last_cls_r [3];
  // combinational
  logic        cpwm, turn_dn, turn_up, eff_up, peak_ev, trough_ev;
  logic [1:0]  run, own_clr, hw_clr, stop_ev;
  logic [2:0]  xfer;
  logic [15:0] period, duty [3], bufv [3];

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;
  assign pwm_pos_pin   = pos_r;
  assign pwm_neg_pin   = neg_r;

  // write address and data are taken independently; the write acts once both are held
  assign wr_fire = aw_got_r & w_got_r & ~bvalid_r;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= ctpw_pkg::RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_got_r  <= 1'b1;
        awready_r <= 1'b0;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        w_got_r  <= 1'b1;
        wready_r <= 1'b0;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_r <= 1'b1;
        bresp_r  <= is_mapped(aw_addr_r) ? ctpw_pkg::RESP_OKAY : ctpw_pkg::RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        aw_got_r  <= 1'b0;
        w_got_r   <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // read data is sampled at the address handshake, so a write finishing in that
  // same cycle is not yet visible
  always_comb begin
    rd_val = 32'h0000_0000;
    if (s_axi_araddr == ctpw_pkg::A_START) begin
      rd_val[3:0] = {csel_r, start_r};
    end else if (s_axi_araddr == ctpw_pkg::A_FUNC) begin
      rd_val[3:0] = {olsn_r, olsp_r, cmd_r};
    end else if (s_axi_araddr == ctpw_pkg::A_MODE) begin
      rd_val[3:0] = bufen_r;
    end else if (s_axi_araddr == ctpw_pkg::A_CAPEN) begin
      rd_val[7:0] = capen_r;
    end
    for (int i = 0; i < 2; i++) begin
      if (ch_hit(s_axi_araddr, i, ctpw_pkg::OFS_CTRL)) rd_val[5:0] = ctrl_r[i];
      if (ch_hit(s_axi_araddr, i, ctpw_pkg::OFS_STAT)) rd_val[5:0] = stat_r[i];
      if (ch_hit(s_axi_araddr, i, ctpw_pkg::OFS_CNT)) rd_val[15:0] = cnt_r[i];
      for (int j = 0; j < 4; j++) begin
        if (ch_hit(s_axi_araddr, i, 8'(ctpw_pkg::OFS_GR + 4 * j))) rd_val[15:0] = gr_r[i][j];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= ctpw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rd_val; // RULE_03
      rresp_r   <= is_mapped(s_axi_araddr) ? ctpw_pkg::RESP_OKAY : ctpw_pkg::RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
    end
  end

  // counting control
  assign cpwm   = cmd_r[1];
  assign period = gr_r[0][0];
  assign turn_dn = dir_up_r & (cnt_r[0] == 16'(period + 16'h0001));
  assign turn_up = ~dir_up_r & (cnt_r[1] == 16'hffff);
  assign eff_up  = dir_up_r ? ~turn_dn : turn_up; // RULE_22
  assign peak_ev   = cpwm & run[0] & dir_up_r & (cnt_r[0] == period); // RULE_14
  assign trough_ev = cpwm & run[1] & ~dir_up_r & (cnt_r[1] == 16'h0000); // RULE_16

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      run[i] = cpwm ? (&start_r & src_tick(ctrl_r[0][2:0], psc_r))
                    : (start_r[i] & src_tick(ctrl_r[i][2:0], psc_r));
      case (ctrl_r[i][5:3]) // RULE_02
        ctpw_pkg::CCLR_A: own_clr[i] = cnt_r[i] == gr_r[i][0];
        ctpw_pkg::CCLR_B: own_clr[i] = cnt_r[i] == gr_r[i][1];
        ctpw_pkg::CCLR_C: own_clr[i] = cnt_r[i] == gr_r[i][2];
        ctpw_pkg::CCLR_D: own_clr[i] = cnt_r[i] == gr_r[i][3];
        default:          own_clr[i] = 1'b0;
      endcase
      own_clr[i] = own_clr[i] & run[i] & ~cpwm;
      stop_ev[i] = run[i] & ~cpwm & ~csel_r[i] & (cnt_r[i] == gr_r[i][0]);
    end
    for (int i = 0; i < 2; i++) begin
      hw_clr[i] = own_clr[i] |
                  ((ctrl_r[i][5:3] == ctpw_pkg::CCLR_SYNC) & own_clr[1 - i]); // RULE_02
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      psc_r <= 5'h00;
    end else begin
      psc_r <= psc_r + 5'h01;
    end
  end

  // start bits; stop select 0 makes a written 0 have no effect
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      start_r <= ctpw_pkg::RST_START;
      csel_r  <= ctpw_pkg::RST_CSEL;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_fire && aw_addr_r == ctpw_pkg::A_START && w_strb_r[0]) begin
          csel_r[i] <= w_data_r[ctpw_pkg::CSEL_LO + i];
          if (w_data_r[ctpw_pkg::START_LO + i] || csel_r[i]) begin // RULE_21
            start_r[i] <= w_data_r[ctpw_pkg::START_LO + i];
          end
        end
        if (stop_ev[i]) start_r[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_r   <= ctpw_pkg::CMD_TIMER;
      olsp_r  <= 1'b0;
      olsn_r  <= 1'b0;
      bufen_r <= 4'h0;
      capen_r <= 8'h00;
      ctrl_r  <= '{default: 6'h00};
    end else if (wr_fire && w_strb_r[0]) begin
      if (aw_addr_r == ctpw_pkg::A_FUNC) begin
        cmd_r  <= w_data_r[1:0];
        olsp_r <= w_data_r[ctpw_pkg::FC_OLSP];
        olsn_r <= w_data_r[ctpw_pkg::FC_OLSN];
      end
      if (aw_addr_r == ctpw_pkg::A_MODE) bufen_r <= w_data_r[3:0];
      if (aw_addr_r == ctpw_pkg::A_CAPEN) capen_r <= w_data_r[7:0];
      for (int i = 0; i < 2; i++) begin
        // count source is used directly; software stops the channel first
        if (ch_hit(aw_addr_r, i, ctpw_pkg::OFS_CTRL)) ctrl_r[i] <= w_data_r[5:0]; // RULE_04
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dir_up_r <= 1'b1;
    end else if (!cpwm) begin
      dir_up_r <= 1'b1;
    end else if (run[0]) begin
      dir_up_r <= eff_up; // RULE_22
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '{default: ctpw_pkg::RST_CNT};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hw_clr[i]) begin
          cnt_r[i] <= 16'h0000; // RULE_01
        end else if (wr_fire && ch_hit(aw_addr_r, i, ctpw_pkg::OFS_CNT)) begin
          cnt_r[i] <= 16'(wmerge({16'h0000, cnt_r[i]}, w_data_r, w_strb_r));
        end else if (run[i]) begin
          cnt_r[i] <= (cpwm && !eff_up) ? cnt_r[i] - 16'h0001 : cnt_r[i] + 16'h0001;
        end
      end
    end
  end

  // capture: pins are synchronous, so one stage plus edge gives two clocks
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_d1_r <= 8'h00;
      cap_d2_r <= 8'h00;
    end else begin
      cap_d1_r <= timer_io_pin;
      cap_d2_r <= cap_d1_r;
    end
  end
  assign cap_ev = cap_d1_r & ~cap_d2_r & capen_r & {8{~cpwm}}; // RULE_06

  // status flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_r <= '{default: 6'h00};
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic [5:0] nxt;
        nxt = stat_r[i];
        if (wr_fire && ch_hit(aw_addr_r, i, ctpw_pkg::OFS_STAT) && w_strb_r[0]) begin
          nxt = stat_r[i] & w_data_r[5:0]; // RULE_20
        end
        for (int j = 0; j < 4; j++) begin
          if ((!cpwm && run[i] && cnt_r[i] == gr_r[i][j]) || cap_ev[4*i+j]) nxt[j] = 1'b1;
        end
        if (run[i] && !cpwm && !hw_clr[i] && cnt_r[i] == 16'hffff) begin
          nxt[ctpw_pkg::SR_OVF] = 1'b1; // RULE_17
        end
        if (i == 0 && peak_ev) nxt[0] = 1'b1; // RULE_14 RULE_15
        if (i == 1 && trough_ev) nxt[ctpw_pkg::SR_UDF] = 1'b1; // RULE_16
        stat_r[i] <= nxt;
      end
    end
  end

  // buffer k feeds duty k: d0 -> b0, c1 -> a1, d1 -> b1
  assign bufv[0] = gr_r[0][3];
  assign bufv[1] = gr_r[1][2];
  assign bufv[2] = gr_r[1][3];
  assign duty[0] = gr_r[0][1];
  assign duty[1] = gr_r[1][0];
  assign duty[2] = gr_r[1][1];

  always_comb begin
    for (int k = 0; k < 3; k++) begin
      case (classify(bufv[k], period))
        ctpw_pkg::CLS_GE:   xfer[k] = trough_ev; // RULE_18
        ctpw_pkg::CLS_ZERO: xfer[k] = peak_ev; // RULE_19
        default: begin
          if (last_cls_r[k] == ctpw_pkg::CLS_GE) xfer[k] = trough_ev; // RULE_18
          else if (last_cls_r[k] == ctpw_pkg::CLS_ZERO) xfer[k] = peak_ev; // RULE_19
          else xfer[k] = (cmd_r == ctpw_pkg::CMD_CP_PK) ? peak_ev : trough_ev; // RULE_14 RULE_16
        end
      endcase
      xfer[k] = xfer[k] & bufen_r[k + 1]; // RULE_13 RULE_15 RULE_17
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_cls_r <= '{default: ctpw_pkg::CLS_NORM};
    end else begin
      for (int k = 0; k < 3; k++) begin
        if (xfer[k]) last_cls_r[k] <= classify(bufv[k], period);
      end
    end
  end

  // general registers: hardware capture and transfer take priority over a bus write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gr_r <= '{default: '{default: ctpw_pkg::RST_GR}};
    end else begin
      for (int i = 0; i < 2; i++) begin
        for (int j = 0; j < 4; j++) begin
          if (wr_fire && ch_hit(aw_addr_r, i, 8'(ctpw_pkg::OFS_GR + 4 * j))) begin
            gr_r[i][j] <= 16'(wmerge({16'h0000, gr_r[i][j]}, w_data_r, w_strb_r)); // RULE_12
          end
          if (cap_ev[4*i+j]) gr_r[i][j] <= cnt_r[i]; // RULE_07
        end
      end
      if (xfer[0]) gr_r[0][1] <= bufv[0];
      if (xfer[1]) gr_r[1][0] <= bufv[1];
      if (xfer[2]) gr_r[1][1] <= bufv[2];
    end
  end

  // channel 0 leads channel 1 by the dead time, so each phase pair has a gap except on the trough step where counter 1 sits at FFFF
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pos_r <= 3'h0;
      neg_r <= 3'h0;
    end else begin
      for (int k = 0; k < 3; k++) begin
        pos_r[k] <= (cpwm && cnt_r[1] > duty[k]) ? olsp_r : ~olsp_r; // RULE_09
        neg_r[k] <= (cpwm && cnt_r[0] < duty[k]) ? olsn_r : ~olsn_r;
      end
    end
  end

endmodule : ctpw_timer

// File: verif/ctpw_timer_sva.sv
`timescale 1ns/1ps
module ctpw_timer_sva (
  input wire logic        clk,           // operating clock
  input wire logic        rstn,          // async reset
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic [1:0]  s_axi_bresp,   // b code
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic [1:0]  s_axi_rresp,   // r code
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready   // r ready
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_aw_taken: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address taken twice");
  a_w_taken: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
    else $error("write data taken twice");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("new write accepted before response");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_b_code: assert property (s_axi_bvalid |-> s_axi_bresp == ctpw_pkg::RESP_OKAY
    || s_axi_bresp == ctpw_pkg::RESP_SLVERR) else $error("write response code unknown");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_r_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not released");
  a_err_zero: assert property (s_axi_rvalid && s_axi_rresp == ctpw_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read carries data");
endmodule : ctpw_timer_sva

bind ctpw_timer ctpw_timer_sva ctpw_timer_sva_i (
  .clk(clk), .rstn(rstn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// File: verif/ctpw_pin_model.sv
`timescale 1ns/1ps
module ctpw_pin_model (
  input  wire logic       clk,          // operating clock
  input  wire logic [2:0] pwm_pos_pin,  // positive phase
  input  wire logic [2:0] pwm_neg_pin,  // negative phase
  output logic      [7:0] timer_io_pin  // capture drive
);
  int   tog_pos = 0;
  int   tog_neg = 0;
  logic last_pos = 1'b0;
  logic last_neg = 1'b0;
  initial timer_io_pin = 8'h00;
  // phase activity only; the driver does not judge dead time
  always @(posedge clk) begin
    if (pwm_pos_pin[0] !== last_pos) tog_pos++;
    if (pwm_neg_pin[0] !== last_neg) tog_neg++;
    last_pos <= pwm_pos_pin[0];
    last_neg <= pwm_neg_pin[0];
  end
  // shorter pulses can slip between input samples
  task automatic pulse(input logic [7:0] m, input int n);
    timer_io_pin <= m;
    repeat (n) @(posedge clk);
    timer_io_pin <= 8'h00;
  endtask : pulse
endmodule : ctpw_pin_model

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [7:0] C0 = ctpw_pkg::A_CH_BASE;
  localparam logic [7:0] C1 = C0 + ctpw_pkg::A_CH_STRIDE;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [7:0]  timer_io_pin;
  logic [2:0]  pwm_pos_pin, pwm_neg_pin;
  logic [2:0]  codes [4] = '{ctpw_pkg::CCLR_A, ctpw_pkg::CCLR_B, ctpw_pkg::CCLR_C,
                             ctpw_pkg::CCLR_D};
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  int          t_pos, t_neg;

  always #2 clk = ~clk;

  ctpw_timer ctpw_timer_i (
    .clk(clk), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(1'b1),
    .timer_io_pin(timer_io_pin), .pwm_pos_pin(pwm_pos_pin), .pwm_neg_pin(pwm_neg_pin));

  ctpw_pin_model ctpw_pin_model_i (
    .clk(clk), .pwm_pos_pin(pwm_pos_pin), .pwm_neg_pin(pwm_neg_pin),
    .timer_io_pin(timer_io_pin));

  task automatic print_verdict();
    if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
  endtask : rd

  task automatic ck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_d & m, e);
  endtask : ck

  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    do rd(a); while ((rd_d & m) === 32'h0);
  endtask : poll

  // counters are loaded ch1 first so the phases never both go active on a stale pair
  task automatic comp(input logic [1:0] md, input logic [15:0] bv, input logic [31:0] pk,
                      input logic [31:0] uf);
    wr(8'h00, 32'h0c);
    wr(8'h04, 32'h0);
    wr(8'h04, {30'h0, md});
    wr(8'h08, 32'h0);
    wr(C0 + 8'h18, {16'h0, bv});
    wr(8'h08, 32'h2);
    wr(C1 + 8'h08, 32'h0);
    wr(C0 + 8'h08, 32'h4);
    wr(C0 + 8'h04, 32'h0);
    wr(C1 + 8'h04, 32'h0);
    wr(8'h00, 32'h0f);
    poll(C0 + 8'h04, 32'h1);
    ck(C0 + 8'h10, 32'hffff, pk);
    poll(C1 + 8'h04, 32'h20);
    ck(C0 + 8'h10, 32'hffff, uf);
  endtask : comp

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    chk({29'h0, pwm_pos_pin}, 32'h7);
    ck(8'h00, 32'hf, {28'h0, ctpw_pkg::RST_CSEL, ctpw_pkg::RST_START});
    ck(C0 + 8'h0c, 32'hffff, {16'h0, ctpw_pkg::RST_GR});
    ck(8'h80, 32'hffffffff, 32'h0);
    chk({30'h0, rsp}, {30'h0, ctpw_pkg::RESP_SLVERR});
    wr(8'h80, 32'h1);
    chk({30'h0, rsp}, {30'h0, ctpw_pkg::RESP_SLVERR});
    for (int j = 0; j < 4; j++) begin
      wr(C0 + 8'h0c + 8'(4 * j), 32'h3);
      wr(C0, {26'h0, codes[j], 3'h0});
      wr(C0 + 8'h08, 32'h0);
      wr(8'h00, 32'h0d);
      repeat (20) @(posedge clk);
      rd(C0 + 8'h08);
      chk({31'h0, rd_d <= 32'h3}, 32'h1);
      wr(8'h00, 32'h0c);
      wr(C0 + 8'h0c + 8'(4 * j), 32'hffff);
    end
    wr(C0, {26'h0, ctpw_pkg::CCLR_A, 3'h0});
    wr(C0 + 8'h0c, 32'h0);
    wr(C0 + 8'h08, 32'h0);
    wr(8'h00, 32'h0d);
    wr(C0 + 8'h08, 32'h5);
    ck(C0 + 8'h08, 32'hffff, 32'h0);
    wr(8'h00, 32'h0c);
    wr(C1 + 8'h0c, 32'h3);
    wr(C1, {26'h0, ctpw_pkg::CCLR_A, 3'h0});
    wr(C0, {26'h0, ctpw_pkg::CCLR_SYNC, 3'h0});
    wr(8'h00, 32'h0f);
    repeat (20) @(posedge clk);
    rd(C0 + 8'h08);
    chk({31'h0, rd_d <= 32'h3}, 32'h1);
    wr(8'h00, 32'h0c);
    wr(C0, 32'h0);
    wr(C1, 32'h3);
    repeat (2) @(posedge clk);
    wr(C1 + 8'h08, 32'h0);
    wr(8'h00, 32'h0e);
    repeat (80) @(posedge clk);
    rd(C1 + 8'h08);
    chk({31'h0, rd_d >= 32'h9 && rd_d <= 32'hc}, 32'h1);
    wr(8'h00, 32'h0c);
    wr(C1, 32'h0);
    wr(C0 + 8'h0c, 32'h0800);
    wr(C0 + 8'h08, 32'h0);
    wr(C0 + 8'h04, 32'h0);
    ck(C0 + 8'h04, 32'h3f, 32'h0);
    wr(8'h00, 32'h01);
    wr(8'h00, 32'h00);
    ck(8'h00, 32'h1, 32'h1);
    do rd(8'h00); while (rd_d[0] === 1'b1);
    ck(C0 + 8'h04, 32'h1, 32'h1);
    wr(C0 + 8'h04, 32'hff);
    ck(C0 + 8'h04, 32'h1, 32'h1);
    wr(C0 + 8'h08, 32'h1234);
    wr(8'h0c, 32'h01);
    wr(C0 + 8'h04, 32'h0);
    ctpw_pin_model_i.pulse(8'h01, 3);
    repeat (3) @(posedge clk);
    ck(C0 + 8'h0c, 32'hffff, 32'h1234);
    ck(C0 + 8'h04, 32'h1, 32'h1);
    wr(8'h0c, 32'h0);
    wr(8'h04, 32'h0);
    wr(8'h04, 32'h1);
    ck(8'h04, 32'hf, 32'h1);
    wr(C0 + 8'h0c, 32'h0040);
    t_pos = ctpw_pin_model_i.tog_pos;
    t_neg = ctpw_pin_model_i.tog_neg;
    comp(ctpw_pkg::CMD_CP_PK, 16'h0020, 32'h20, 32'h20);
    comp(ctpw_pkg::CMD_CP_PK, 16'h0050, 32'h20, 32'h50);
    comp(ctpw_pkg::CMD_CP_UF, 16'h0000, 32'h00, 32'h00);
    comp(ctpw_pkg::CMD_CP_UF, 16'h0010, 32'h10, 32'h10);
    comp(ctpw_pkg::CMD_CP_UF, 16'h0018, 32'h10, 32'h18);
    chk({31'h0, ctpw_pin_model_i.tog_pos > t_pos}, 32'h1);
    chk({31'h0, ctpw_pin_model_i.tog_neg > t_neg}, 32'h1);
    wr(8'h00, 32'h0c);
    wr(8'h04, 32'h0);
    repeat (2) @(posedge clk);
    chk({26'h0, pwm_neg_pin, pwm_pos_pin}, 32'h3f);
    print_verdict();
  end
endmodule : tb_top
